/* File: include/sphp_defs.vh */
// constants for the solenoid peak/hold pwm controller
`ifndef SPHP_DEFS_VH
`define SPHP_DEFS_VH
`define SPHP_CLK_MHZ 50
`define SPHP_PWM_DEF_KHZ 20
`define SPHP_PWM_DEF_CYC ((`SPHP_CLK_MHZ * 1000) / `SPHP_PWM_DEF_KHZ)
`define SPHP_DMIN_PCT 7'h09
`define SPHP_PCT_FULL 7'h64
`define SPHP_DWELL_MV 75
`define SPHP_DWELL_UV 24'h0124F8
`define SPHP_PEAK_DEF_MA 16'h00C8
`define SPHP_HOLD_DEF_MA 16'h0032
`define SPHP_ST_OFF 2'h0
`define SPHP_ST_PEAK 2'h1
`define SPHP_ST_HOLD 2'h2
`define SPHP_TD_MAX_US 50
`endif

/* File: src/sphp_tick_gen.v */
// switching tick divider with default or external period
`timescale 1ns/1ps
`include "sphp_defs.vh"
module sphp_tick_gen #(
   parameter W = 16,
   parameter [W-1:0] DEF_PERIOD = `SPHP_PWM_DEF_CYC
) (
   // clock and reset
   input wire clk,
   input wire nrst,
   // control
   input wire run,
   input wire rateGrounded,
   input wire [W-1:0] extPeriod,
   // outputs
   output reg tick,
   output reg [W-1:0] period
);
   reg [W-1:0] cnt_reg;

   // counter restarts when idle so the first tick follows run at once
   always @(posedge clk) begin
      if (!nrst) begin
         cnt_reg <= {W{1'b0}};
         tick <= 1'b0;
         period <= DEF_PERIOD;
      end else begin
         period <= rateGrounded ? DEF_PERIOD : extPeriod;
         if (!run) begin
            cnt_reg <= {W{1'b0}};
            tick <= 1'b0;
         end else if (cnt_reg == {W{1'b0}}) begin
            cnt_reg <= period - 1'b1;
            tick <= 1'b1;
         end else begin
            cnt_reg <= cnt_reg - 1'b1;
            tick <= 1'b0;
         end
      end
   end
endmodule // sphp_tick_gen

/* File: src/sphp_controller.v */
// peak/hold pwm control for a low-side solenoid driver
// What this block does
// - enable high leaves off, enters inrush
// - undriven enable reads as high
// - inrush level until dwell, then sustain
// - sustain holds while enable stays high
// - enable low returns off, switching stops
// - exactly three states; off keeps switch off
// - dwell ramp reaching threshold selects sustain level
// - switch conducts while sense below threshold
// - sense above threshold: off until tick
// - every comparator chop keeps least on-time; enable low or a fault cuts at once
// - least on nine percent, max hundred
// - grounded level input selects internal defaults
// - inrush and sustain defaults chosen independently
// - grounded rate pin selects default rate
// - fault status pulls low unless fault
// - switching starts within start-up delay
`timescale 1ns/1ps
`include "sphp_defs.vh"
module sphp_controller #(
   parameter W = 16,
   parameter LW = 16,
   parameter DW = 24,
   parameter [DW-1:0] DWELL_STEP = 24'h000001
) (
   // clock and reset
   input wire clk,
   input wire nrst,
   // enable pin; enIn is the driven level, enDriven low means floating
   input wire enIn,
   input wire enDriven,
   // level settings (grounded or below resistance threshold means internal)
   input wire peakInternal,
   input wire [LW-1:0] peakExtMa,
   input wire holdInternal,
   input wire [LW-1:0] holdExtMa,
   // rate setting
   input wire rateGrounded,
   input wire [W-1:0] rateExtPeriod,
   // dwell: ramp slope per cycle in microvolts
   input wire [DW-1:0] dwellSlopeUv,
   // current comparator: high when sensed above threshold
   input wire senseAbove,
   // faults
   input wire supplyLow,
   input wire overTemp,
   // outputs
   output reg switchOn,
   output reg [LW-1:0] thresholdMa,
   output reg [1:0] state,
   output reg statusPullOe,
   output reg statusPullOut
);
   // state codes from the header; the bench repeats them as literals
   localparam [1:0] ST_OFF = `SPHP_ST_OFF;
   localparam [1:0] ST_PEAK = `SPHP_ST_PEAK;
   localparam [1:0] ST_HOLD = `SPHP_ST_HOLD;
   // dwell threshold in microvolts and least on-time arithmetic
   localparam [DW-1:0] DWELL_UV = `SPHP_DWELL_UV;
   localparam [6:0] DMIN_PCT = `SPHP_DMIN_PCT;
   localparam [6:0] PCT_FULL = `SPHP_PCT_FULL;
   localparam [W-1:0] ONE_CYC = {{(W-1){1'b0}}, 1'b1};
   localparam [W-1:0] CNT_TOP = {W{1'b1}};

   // enable synchroniser
   reg enSync1_reg;
   reg enSync2_reg;
   // sequencer
   reg [1:0] state_next;
   // dwell ramp
   reg [DW-1:0] ramp_reg;
   reg [DW-1:0] ramp_next;
   // on-cycle bookkeeping
   reg [W-1:0] onCnt_reg;
   reg [W-1:0] onCnt_next;
   reg chopped_reg;
   reg chopped_next;
   reg switch_next;
   // combinational helpers
   wire enLevel;
   wire fault;
   wire tickRun;
   wire tick;
   wire [W-1:0] period;
   wire [W+6:0] minProd;
   wire [W+6:0] minDiv;
   wire [W-1:0] minOn;
   wire inMin;
   wire dwellDone;
   wire [DW-1:0] rampStep;
   wire [DW:0] rampSum;

   // a floating pin reads high through its pull-up
   assign enLevel = enDriven ? enIn : 1'b1;
   // either fault forces the switch off and the sequencer to off
   assign fault = supplyLow | overTemp;
   // the divider only runs while activated
   assign tickRun = (state != ST_OFF);

   // least on-time is 9 % of the active period; never below one cycle
   // so a very short external period still gives a real pulse
   assign minProd = period * DMIN_PCT;
   assign minDiv = minProd / PCT_FULL;
   assign minOn = (minDiv == {(W+7){1'b0}}) ? ONE_CYC : minDiv[W-1:0];
   assign inMin = onCnt_reg < minOn;

   // dwell ramp: the step is the slope scaled by the build-time factor;
   // the sum is one bit wider so a large step cannot wrap past the threshold
   assign rampStep = dwellSlopeUv * DWELL_STEP;
   assign rampSum = {1'b0, ramp_reg} + {1'b0, rampStep};
   assign dwellDone = (ramp_reg >= DWELL_UV);

   // two-flop synchroniser on enable; only the second flop is read
   always @(posedge clk) begin
      if (!nrst) begin
         enSync1_reg <= 1'b0;
         enSync2_reg <= 1'b0;
      end else begin
         enSync1_reg <= enLevel;
         enSync2_reg <= enSync1_reg;
      end
   end

   // three-state sequencer; an illegal code falls back to off
   always @* begin
      state_next = state;
      case (state)
         ST_OFF: begin
            if (enSync2_reg && !fault) state_next = ST_PEAK;
         end
         ST_PEAK: begin
            if (!enSync2_reg || fault) state_next = ST_OFF;
            else if (dwellDone) state_next = ST_HOLD;
         end
         ST_HOLD: begin
            // no time limit: only enable low or a fault ends sustain
            if (!enSync2_reg || fault) state_next = ST_OFF;
         end
         default: state_next = ST_OFF;
      endcase
   end

   // state register
   always @(posedge clk) begin
      if (!nrst) begin
         state <= ST_OFF;
      end else begin
         state <= state_next;
      end
   end

   // ramp next value: cleared in off so every activation gets a full dwell
   always @* begin
      ramp_next = ramp_reg;
      if (state == ST_OFF) begin
         ramp_next = {DW{1'b0}};
      end else if (state == ST_PEAK && !dwellDone) begin
         if (rampSum[DW]) ramp_next = DWELL_UV; // saturate instead of wrapping
         else ramp_next = rampSum[DW-1:0];
      end
   end

   // dwell ramp register
   always @(posedge clk) begin
      if (!nrst) begin
         ramp_reg <= {DW{1'b0}};
      end else begin
         ramp_reg <= ramp_next;
      end
   end

   // tick generator runs only while activated; first tick comes at once
   sphp_tick_gen #(.W(W)) uTick (
      .clk(clk),
      .nrst(nrst),
      .run(tickRun),
      .rateGrounded(rateGrounded),
      .extPeriod(rateExtPeriod),
      .tick(tick),
      .period(period)
   );

   // active threshold follows state_next so it is ready with the new state;
   // inrush and sustain sources are picked separately
   always @(posedge clk) begin
      if (!nrst) begin
         thresholdMa <= `SPHP_PEAK_DEF_MA;
      end else if (state_next == ST_HOLD) begin
         thresholdMa <= holdInternal ? `SPHP_HOLD_DEF_MA : holdExtMa;
      end else begin
         thresholdMa <= peakInternal ? `SPHP_PEAK_DEF_MA : peakExtMa;
      end
   end

   // on-cycle: a tick turns the switch on, the comparator chops it after
   // the least on-time; the comparator is seen one cycle late, a small
   // overshoot traded for a fully registered switch output
   always @* begin
      switch_next = switchOn;
      chopped_next = chopped_reg;
      onCnt_next = onCnt_reg;
      if (state_next == ST_OFF) begin
         switch_next = 1'b0;
         chopped_next = 1'b1;
         onCnt_next = {W{1'b0}};
      end else if (tick) begin
         switch_next = 1'b1;
         chopped_next = 1'b0;
         onCnt_next = ONE_CYC;
      end else begin
         // the count stops at its top so a full-on cycle cannot wrap
         if (onCnt_reg != CNT_TOP) onCnt_next = onCnt_reg + ONE_CYC;
         if (!chopped_reg && !inMin && senseAbove) begin
            switch_next = 1'b0;
            chopped_next = 1'b1;
         end else begin
            switch_next = !chopped_reg;
         end
      end
   end

   // on-cycle registers
   always @(posedge clk) begin
      if (!nrst) begin
         onCnt_reg <= {W{1'b0}};
         chopped_reg <= 1'b1;
         switchOn <= 1'b0;
      end else begin
         onCnt_reg <= onCnt_next;
         chopped_reg <= chopped_next;
         switchOn <= switch_next;
      end
   end

   // open-drain status: the pull-down is enabled while healthy and
   // released on either fault; the driven level itself is always low
   always @(posedge clk) begin
      if (!nrst) begin
         statusPullOe <= 1'b0;
         statusPullOut <= 1'b0;
      end else begin
         statusPullOe <= !fault;
         statusPullOut <= 1'b0;
      end
   end
endmodule // sphp_controller

/* File: testbench/sphp_controller_monitor.sv */
// port checks for the peak/hold controller
`timescale 1ns/1ps
module sphp_controller_monitor (
   // watched ports
   input wire clk,
   input wire nrst,
   input wire enIn,
   input wire enDriven,
   input wire supplyLow,
   input wire overTemp,
   input wire switchOn,
   input wire [1:0] state,
   input wire statusPullOe
);
   // a floating enable reads high
   wire en = enIn | ~enDriven;
   wire flt = supplyLow | overTemp;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // three samples cover the enable synchroniser
   sequence onReq; (en && !flt)[*3]; endsequence
   sequence offReq; (!en)[*3]; endsequence
   a_en_start: assert property (onReq |=> state != 2'h0) else $error("start");
   a_en_stop: assert property (offReq |=> state == 2'h0 && !switchOn) else $error("stop");
   a_fault_stop: assert property (flt |=> state == 2'h0 && !switchOn) else $error("fault");
   a_status_pull: assert property ($past(nrst) |-> statusPullOe == !$past(flt)) else $error("status");
   a_state_legal: assert property (state != 2'h3) else $error("state");
   a_off_quiet: assert property (state == 2'h0 |-> !switchOn) else $error("off");
   a_hold_stays: assert property (onReq ##0 state == 2'h2 |=> state == 2'h2) else $error("hold");
   a_hold_order: assert property (state == 2'h2 |-> $past(state) != 2'h0) else $error("order");
endmodule // sphp_controller_monitor
bind sphp_controller sphp_controller_monitor mon (.*);

/* File: testbench/sphp_load_model.sv */
// coil model: current rises while switched on
`timescale 1ns/1ps
module sphp_load_model (
   // driver side
   input wire clk,
   input wire switchOn,
   input wire [15:0] thresholdMa,
   output wire senseAbove
);
   reg [15:0] curReg = 16'h0000;
   // decay slower than rise, as through a freewheel diode
   always @(posedge clk) begin
      if (switchOn) curReg <= curReg + 16'h0008;
      else if (curReg != 16'h0000) curReg <= curReg - 16'h0001;
   end
   assign senseAbove = curReg > thresholdMa;
endmodule // sphp_load_model

/* File: testbench/sphp_controller_tb.sv */
// bench for the peak/hold controller
`timescale 1ns/1ps
module sphp_controller_tb;
   reg clk, nrst = 1'h0, en = 1'h0, drv = 1'h1, pk = 1'h1, rg = 1'h1, uv = 1'h0, ot = 1'h0, hi = 1'h1;
   wire sw, pOe, sns;
   wire [15:0] thr;
   wire [1:0] st;
   integer bad_count = 0, checks = 0, cyc = 0, i, k;
   // 100-cycle external period, 15-cycle dwell
   sphp_controller dut (.clk(clk), .nrst(nrst), .enIn(en), .enDriven(drv), .peakInternal(pk),
      .peakExtMa(16'h00FA), .holdInternal(hi), .holdExtMa(16'h0064), .rateGrounded(rg),
      .rateExtPeriod(16'h0064), .dwellSlopeUv(24'h001388), .senseAbove(sns), .supplyLow(uv),
      .overTemp(ot), .switchOn(sw), .thresholdMa(thr), .state(st), .statusPullOe(pOe), .statusPullOut());
   sphp_load_model coil (.clk(clk), .switchOn(sw), .thresholdMa(thr), .senseAbove(sns));
   task chk(input [15:0] g, input [15:0] e);
      begin
         checks = checks + 1;
         if (g !== e) begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED %0t got %h", $time, g);
         end
      end
   endtask
   // s of 3 waits for the switch instead
   task wt(input [1:0] s);
      begin
         for (i = 0; i < 2500 && (s == 2'h3 ? sw !== 1'h1 : st !== s); i = i + 1)
            @(negedge clk);
         chk({15'h0000, i < 2500}, 16'h0001);
      end
   endtask
   task end_of_test;
      begin
         $display("%0d checks, %0d bad", checks, bad_count);
         if (bad_count == 0 && checks > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   // clock, then a run ceiling
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 9000) begin
         bad_count = bad_count + 1;
         end_of_test;
      end
   end
   // pin level held low while floating
   initial begin
      repeat (20) @(posedge clk);
      nrst <= 1'h1;
      @(posedge clk);
      drv <= 1'h0;
      wt(2'h1);
      chk(thr, 16'h00C8);
      wt(2'h2);
      chk(thr, 16'h0032);
      wt(2'h3);
      @(posedge clk);
      drv <= 1'h1;
      wt(2'h0);
      @(posedge clk);
      pk <= 1'h0;
      rg <= 1'h0;
      en <= 1'h1;
      wt(2'h1);
      chk(thr, 16'h00FA);
      @(posedge clk);
      hi <= 1'h0;
      wt(2'h3);
      // 100-cycle period: at least 9 cycles on, chopped before the next tick
      for (i = 0; i < 100 && sw === 1'h1; i = i + 1)
         @(negedge clk);
      chk({14'h0000, i >= 9, i < 100}, 16'h0003);
      wt(2'h2);
      chk(thr, 16'h0064);
      $display("activation test done");
      for (k = 0; k < 2; k = k + 1) begin
         @(posedge clk);
         {uv, ot} <= k ? 2'h1 : 2'h2;
         @(posedge clk);
         @(negedge clk);
         chk({12'h000, st, sw, pOe}, 16'h0000);
         @(posedge clk);
         {uv, ot} <= 2'h0;
         wt(2'h1);
         chk({15'h0000, pOe}, 16'h0001);
      end
      $display("fault test done");
      end_of_test;
   end
endmodule // sphp_controller_tb
